//--- common/bucket_pkg.sv
package bucket_pkg;
  // Clock and evaluation cycle timing
  localparam int CLK_FREQ_HZ   = 10_000_000;
  localparam int CYCLE_TIME_MS = 128;
  localparam int CYCLE_CLKS    = CYCLE_TIME_MS * (CLK_FREQ_HZ / 1000);

  // Register offsets
  localparam logic [7:0] ADDR_DRAIN_RATE_CFG2 = 8'h58;
  localparam logic [7:0] ADDR_ALARM_SET_CFG3  = 8'h5c;

  // Reset values
  localparam logic [7:0] DRAIN_RATE_RESET = 8'h01;
  localparam logic [7:0] ALARM_SET_RESET  = 8'h06;

  // Drain rate field layout
  localparam int DRAIN_FIELD_LSB = 0;
  localparam int DRAIN_FIELD_W   = 2;
  localparam logic [7:0] DRAIN_FIELD_MASK = 8'h03;

  // Longest quiet span, in cycles
  localparam int MAX_DRAIN_SPAN = 8;
endpackage

//--- logic/cycle_tick.sv
`timescale 1ns/1ps
module cycle_tick #(
  parameter int PERIOD = 16                    // Clocks per tick
) (
  input  wire logic sys_clk,                   // System clock
  input  wire logic resetn,                    // Async reset, active low
  output logic      tick                       // One-cycle pulse per period
);
  localparam int CW = (PERIOD > 1) ? $clog2(PERIOD) : 1;
  localparam logic [CW-1:0] LAST = CW'(PERIOD - 1);

  logic [CW-1:0] count_r;

  // Free-running period counter
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      count_r <= '0;
      tick    <= 1'b0;
    end else begin
      tick <= (count_r == LAST);
      if (count_r == LAST) begin
        count_r <= '0;
      end else begin
        count_r <= count_r + 1'b1;
      end
    end
  end
endmodule

//--- logic/leaky_bucket_activity_monitor.sv
`timescale 1ns/1ps
// Overview of operation
// - Each 128 ms cycle in which a failure or erratic event was seen adds one to the bucket.
// - Each run of 1, 2, 4 or 8 event-free cycles, per the drain setting, takes one away.
// - Drain speed is thus the fill speed, or one half, quarter or eighth of it.
// - The inactivity alarm rises when the bucket reaches the alarm set level.
// - A raised alarm clears once the bucket falls to the lower threshold.
module leaky_bucket_activity_monitor #(
  parameter int CYCLE_CLKS = bucket_pkg::CYCLE_CLKS,  // Clocks per evaluation cycle
  parameter int LEVEL_W    = 8                        // Bucket width
) (
  input  wire logic               sys_clk,       // System clock, 10 MHz
  input  wire logic               resetn,        // Async reset, active low
  input  wire logic               failEvent,     // Input failed or erratic, pulse or level
  input  wire logic [LEVEL_W-1:0] lowerLevel,    // Alarm clearing level
  input  wire logic [LEVEL_W-1:0] bucketSize,    // Bucket fill cap
  input  wire logic [7:0]         regAddr,       // Register address
  input  wire logic               regWrEn,       // Register write strobe
  input  wire logic [7:0]         regWrData,     // Register write data
  output logic      [7:0]         regRdData_r,   // Registered read data
  output logic      [LEVEL_W-1:0] bucketLevel_r, // Current accumulator
  output logic                    alarm_r        // Inactivity alarm
);
  import bucket_pkg::*;

  logic [7:0] drainRate_r;
  logic [7:0] alarmSet_r;
  logic       failSeen_r;
  logic [3:0] quietCnt_r;
  logic [3:0] quietCnt_nxt;
  logic [3:0] drainSpan;
  logic       tick;
  logic       failNow;
  logic       drainNow;

  cycle_tick #(
    .PERIOD (CYCLE_CLKS)
  ) u_tick (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .tick    (tick)
  );

  // Register writes; unused drain bits are masked off
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      drainRate_r <= DRAIN_RATE_RESET;
      alarmSet_r  <= ALARM_SET_RESET;
    end else if (regWrEn) begin
      if (regAddr == ADDR_DRAIN_RATE_CFG2) begin
        drainRate_r <= regWrData & DRAIN_FIELD_MASK;
      end
      if (regAddr == ADDR_ALARM_SET_CFG3) begin
        alarmSet_r <= regWrData;
      end
    end
  end

  // Read mux, registered so the port is a flop; unmapped reads give zero
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      regRdData_r <= 8'h00;
    end else begin
      unique case (regAddr)
        ADDR_DRAIN_RATE_CFG2: regRdData_r <= drainRate_r & DRAIN_FIELD_MASK;
        ADDR_ALARM_SET_CFG3:  regRdData_r <= alarmSet_r;
        default:              regRdData_r <= 8'h00;
      endcase
    end
  end

  // Event latch; an event in the tick cycle counts now, so nothing is lost
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      failSeen_r <= 1'b0;
    end else if (tick) begin
      failSeen_r <= 1'b0;
    end else if (failEvent) begin
      failSeen_r <= 1'b1;
    end
  end

  // Drain span decode: 1, 2, 4 or 8 cycles
  assign drainSpan    = 4'h1 << drainRate_r[DRAIN_FIELD_LSB +: DRAIN_FIELD_W];
  assign failNow      = failSeen_r | failEvent;
  assign quietCnt_nxt = quietCnt_r + 4'h1;
  // Compare with >= so a lowered rate mid-span never leaves the count stuck
  assign drainNow     = tick && !failNow && (quietCnt_nxt >= drainSpan);

  // Quiet-cycle counter, restarted by any event
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      quietCnt_r <= 4'h0;
    end else if (tick) begin
      if (failNow || drainNow) begin
        quietCnt_r <= 4'h0;
      end else begin
        quietCnt_r <= quietCnt_nxt;
      end
    end
  end

  // Accumulator: fill capped by bucket size, drain floored at zero
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      bucketLevel_r <= '0;
    end else if (tick && failNow) begin
      if (bucketLevel_r < bucketSize) begin
        bucketLevel_r <= bucketLevel_r + 1'b1;
      end
    end else if (drainNow && (bucketLevel_r != '0)) begin
      bucketLevel_r <= bucketLevel_r - 1'b1;
    end
  end

  // Alarm with hysteresis; set level wins if thresholds overlap
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      alarm_r <= 1'b0;
    end else if (bucketLevel_r >= alarmSet_r[LEVEL_W-1:0]) begin
      alarm_r <= 1'b1;
    end else if (bucketLevel_r <= lowerLevel) begin
      alarm_r <= 1'b0;
    end
  end

  sequence fillTick;
    tick && failNow && (bucketLevel_r < bucketSize);
  endsequence

  sequence drainTick;
    drainNow && (bucketLevel_r != '0);
  endsequence

  // Per-cycle outcomes, used by the quiet-span counter checks
  sequence failTick;
    tick && failNow;
  endsequence

  sequence quietTick;
    tick && !failNow && !drainNow;
  endsequence

  AST_FILL: assert property (@(posedge sys_clk) disable iff (!resetn)
    fillTick |=> bucketLevel_r == $past(bucketLevel_r) + 1'b1)
    else $error("bucket did not fill on failed cycle");

  AST_HOLD_OFF_TICK: assert property (@(posedge sys_clk) disable iff (!resetn)
    !tick |=> $stable(bucketLevel_r))
    else $error("bucket moved between cycles");

  AST_DRAIN: assert property (@(posedge sys_clk) disable iff (!resetn)
    drainTick |=> bucketLevel_r == $past(bucketLevel_r) - 1'b1)
    else $error("bucket did not drain after quiet span");

  AST_SPAN_DECODE: assert property (@(posedge sys_clk) disable iff (!resetn)
    drainNow |-> (quietCnt_r == drainSpan - 4'h1) || (quietCnt_r >= drainSpan))
    else $error("drain fired before span complete");

  AST_SPAN_BOUND: assert property (@(posedge sys_clk) disable iff (!resetn)
    quietCnt_r < 4'(MAX_DRAIN_SPAN))
    else $error("quiet count beyond slowest drain span");

  AST_ALARM_SET: assert property (@(posedge sys_clk) disable iff (!resetn)
    (bucketLevel_r >= alarmSet_r) |=> alarm_r)
    else $error("alarm not raised at set level");

  AST_ALARM_CLR: assert property (@(posedge sys_clk) disable iff (!resetn)
    (bucketLevel_r <= lowerLevel) && (bucketLevel_r < alarmSet_r) |=> !alarm_r)
    else $error("alarm not cleared at lower level");

  AST_ALARM_HOLD: assert property (@(posedge sys_clk) disable iff (!resetn)
    alarm_r && (bucketLevel_r > lowerLevel) |=> alarm_r)
    else $error("alarm dropped above lower level");

  AST_RSVD_ZERO: assert property (@(posedge sys_clk) disable iff (!resetn)
    (regAddr == ADDR_DRAIN_RATE_CFG2) |=> regRdData_r[7:2] == 6'h00)
    else $error("unused drain bits read nonzero");

  // Latch and fill-cap checks; a lost event would turn a fill into a drain
  AST_FAIL_LATCH: assert property (@(posedge sys_clk) disable iff (!resetn)
    (failEvent && !tick) |=> failSeen_r)
    else $error("failure between cycles not latched");

  AST_LATCH_CLEAR: assert property (@(posedge sys_clk) disable iff (!resetn)
    tick |=> !failSeen_r)
    else $error("failure latch not cleared at cycle end");

  AST_FILL_CAP: assert property (@(posedge sys_clk) disable iff (!resetn)
    (tick && failNow && (bucketLevel_r >= bucketSize)) |=> $stable(bucketLevel_r))
    else $error("bucket filled past its size");

  // Quiet-span counter checks, then the drain floor check
  AST_FAIL_CLR_QUIET: assert property (@(posedge sys_clk) disable iff (!resetn)
    failTick |=> (quietCnt_r == 4'h0))
    else $error("quiet count kept across a failed cycle");

  AST_QUIET_STEP: assert property (@(posedge sys_clk) disable iff (!resetn)
    quietTick |=> (quietCnt_r == $past(quietCnt_r) + 4'h1))
    else $error("quiet count did not advance");

  AST_FLOOR: assert property (@(posedge sys_clk) disable iff (!resetn)
    (drainNow && (bucketLevel_r == '0)) |=> (bucketLevel_r == '0))
    else $error("bucket drained below zero");

  // Slowest code must see seven quiet cycles before the eighth drains
  AST_SPAN_EIGHT: assert property (@(posedge sys_clk) disable iff (!resetn)
    (drainNow && (drainRate_r[DRAIN_FIELD_LSB +: DRAIN_FIELD_W] == 2'b11))
      |-> (quietCnt_r == 4'h7))
    else $error("slowest drain fired off its span");

  // Fastest code drains on every quiet cycle, matching the fill rate
  AST_SPAN_ONE: assert property (@(posedge sys_clk) disable iff (!resetn)
    (tick && !failNow && (drainRate_r[DRAIN_FIELD_LSB +: DRAIN_FIELD_W] == 2'b00))
      |-> drainNow)
    else $error("fastest drain skipped a quiet cycle");

  AST_RATE_MASK: assert property (@(posedge sys_clk) disable iff (!resetn)
    drainRate_r[7:2] == 6'h00)
    else $error("unused drain bits were stored");

  AST_SET_WRITE: assert property (@(posedge sys_clk) disable iff (!resetn)
    (regWrEn && (regAddr == ADDR_ALARM_SET_CFG3)) |=> (alarmSet_r == $past(regWrData)))
    else $error("alarm set level write lost");

  // Alarm edges only where the thresholds allow them
  AST_ALARM_RISE: assert property (@(posedge sys_clk) disable iff (!resetn)
    $rose(alarm_r) |-> ($past(bucketLevel_r) >= $past(alarmSet_r)))
    else $error("alarm rose below set level");

  AST_ALARM_FALL: assert property (@(posedge sys_clk) disable iff (!resetn)
    $fell(alarm_r) |-> ($past(bucketLevel_r) <= $past(lowerLevel)))
    else $error("alarm fell above lower level");
endmodule

//--- verification/tb_leaky_bucket_activity_monitor.sv
`timescale 1ns/1ps
module tb_leaky_bucket_activity_monitor;
  import bucket_pkg::*;
  localparam int CYC = 16;             // Short evaluation cycle keeps the run brief
  logic       sys_clk = 1'b0;
  logic       resetn;
  logic       failEvent;
  logic [7:0] lowerLevel;
  logic [7:0] bucketSize;
  logic [7:0] regAddr;
  logic       regWrEn;
  logic [7:0] regWrData;
  logic [7:0] regRdData_r;
  logic [7:0] bucketLevel_r;
  logic       alarm_r;
  int         badCount = 0;
  int         comparisons = 0;

  // Clock, 100 ns period
  always #50 sys_clk = ~sys_clk;

  leaky_bucket_activity_monitor #(.CYCLE_CLKS(CYC), .LEVEL_W(8)) u_dut (
    .sys_clk(sys_clk), .resetn(resetn), .failEvent(failEvent), .lowerLevel(lowerLevel),
    .bucketSize(bucketSize), .regAddr(regAddr), .regWrEn(regWrEn), .regWrData(regWrData),
    .regRdData_r(regRdData_r), .bucketLevel_r(bucketLevel_r), .alarm_r(alarm_r));

  // Inputs move 1 ns after the edge, so no race with the sampling edge
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      badCount++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    step(1);
    regWrEn = 1'b0;
  endtask

  // Read data is registered, so allow the address a full cycle to settle
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    regAddr = a;
    step(2);
    chk("read data", exp, regRdData_r);
  endtask

  task automatic waitLevel(input logic [7:0] v);
    int n;
    n = 0;
    while (bucketLevel_r !== v && n < 2000) begin
      step(1);
      n++;
    end
    chk("bucket level", v, bucketLevel_r);
  endtask

  // First change may be early after a rate change; only the second gap is timed
  task automatic gap(input int expClks);
    logic [7:0] old;
    int         n;
    old = bucketLevel_r;
    for (int k = 0; k < 2; k++) begin
      old = bucketLevel_r;
      n = 0;
      while (bucketLevel_r === old && n < 2000) begin
        step(1);
        n++;
      end
    end
    chk("gap clocks", expClks[15:0], n[15:0]);
  endtask

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", comparisons, badCount);
    if (badCount == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    resetn = 1'b0;
    failEvent = 1'b0;
    lowerLevel = 8'h01;
    bucketSize = 8'h05;
    regAddr = 8'h00;
    regWrEn = 1'b0;
    regWrData = 8'h00;
    step(4);
    resetn = 1'b1;
    rd(ADDR_DRAIN_RATE_CFG2, DRAIN_RATE_RESET);
    rd(ADDR_ALARM_SET_CFG3, ALARM_SET_RESET);
    rd(8'h40, 8'h00);
    wr(ADDR_DRAIN_RATE_CFG2, 8'hff);
    rd(ADDR_DRAIN_RATE_CFG2, 8'h03);
    wr(ADDR_ALARM_SET_CFG3, 8'h03);
    rd(ADDR_ALARM_SET_CFG3, 8'h03);
    $display("register test done");
    failEvent = 1'b1;
    waitLevel(8'h02);
    step(1);
    chk("alarm", 8'h00, {7'h00, alarm_r});
    waitLevel(8'h03);
    step(1);
    chk("alarm", 8'h01, {7'h00, alarm_r});
    gap(CYC);
    step(CYC * 3);
    chk("bucket cap", bucketSize, bucketLevel_r);
    $display("fill test done");
    // Each drain code timed from a full bucket
    for (int r = 3; r >= 0; r--) begin
      failEvent = 1'b1;
      waitLevel(bucketSize);
      failEvent = 1'b0;
      wr(ADDR_DRAIN_RATE_CFG2, 8'(r));
      gap(CYC << r);
    end
    $display("drain test done");
    waitLevel(8'h02);
    step(1);
    chk("alarm", 8'h01, {7'h00, alarm_r});
    waitLevel(8'h01);
    step(1);
    chk("alarm", 8'h00, {7'h00, alarm_r});
    waitLevel(8'h00);
    step(CYC * 2);
    chk("bucket floor", 8'h00, bucketLevel_r);
    $display("clear test done");
    summarize;
  end

  // Watchdog, far beyond the roughly 790 clocks the tests need
  initial begin
    #2_000_000;
    badCount++;
    summarize;
  end
endmodule
